// >>> logic/exec_alu.v
// Combinational arithmetic and logic unit for the execution core
`timescale 1ns/1ps
`default_nettype none

`include "exec_defines.vh"

module exec_alu (
   // Operation select
   input  wire [2:0] op,
   // Operands
   input  wire [7:0] acc,
   input  wire [7:0] literal,
   input  wire [7:0] fval,
   // Result and flags
   output reg  [7:0] result,
   output reg        borrow_not,
   output reg        nib_borrow_not,
   output wire       null_res,
   output reg        upd_arith,
   output reg        upd_null
);

   reg [8:0] diff;   // Full difference with carry out
   reg [4:0] ndiff;  // Low nibble difference
   reg [7:0] minu;   // Minuend: literal or register

   // Result path and flag enables per operation
   always @* begin
      minu           = (op == `OP_SUB_LIT) ? literal : fval;
      // Two's complement: add the inverse plus one, carry out means no borrow
      diff           = {1'b0, minu} + {1'b0, ~acc} + 9'h001;
      ndiff          = {1'b0, minu[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      borrow_not     = diff[8];
      nib_borrow_not = ndiff[4];
      upd_arith      = 1'b0;
      upd_null       = 1'b0;
      case (op)
         `OP_SUB_LIT, `OP_SUB_REG: begin
            result    = diff[7:0];
            upd_arith = 1'b1;
            upd_null  = 1'b1;
         end
         `OP_XOR_LIT: begin
            result   = acc ^ literal;
            upd_null = 1'b1;
         end
         `OP_XOR_REG: begin
            result   = acc ^ fval;
            upd_null = 1'b1;
         end
         // Nibble exchange touches no flag
         `OP_SWAP: result = {fval[3:0], fval[7:4]};
         default:  result = 8'h00;
      endcase
   end

   // Zero test on the 8-bit result
   assign null_res = (result == 8'h00);

endmodule

`default_nettype wire

// >>> logic/exec_core.v
// Execution core for an 8-bit instruction subset with APB register access
//
// Behaviour
// - Return pops stack into PC, flags kept
// - Return takes two instruction cycles
// - Sleep clears watchdog counter and prescaler
// - Sleep clears powerdown, sets timeout flag
// - Sleep halts execution until wake
// - Literal minus accumulator into accumulator, arithmetic flags
// - Register minus accumulator to destination, flags
// - Destination bit: 0 accumulator, 1 register
// - Literal XOR into accumulator, null flag only
// - Register XOR to destination, null flag only
// - Nibble swap to destination, no flags
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "exec_defines.vh"

module exec_core #(
   parameter PC_W       = 13,
   parameter STK_LOG2   = 3,
   parameter FILE_DEPTH = 128
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Core state
   output reg         low_power
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   reg  [2:0]      div_r;        // Instruction cycle divider
   reg             tick_r;       // One-cycle instruction enable
   reg  [2:0]      op_r;         // Pending operation
   reg             dest_r;       // Destination select
   reg  [6:0]      faddr_r;      // Operand register address
   reg  [7:0]      lit_r;        // Immediate byte
   reg             pend_r;       // Instruction waiting for a tick
   reg             ret2_r;       // Second cycle of a return
   reg  [7:0]      acc_r;        // Accumulator
   reg             bn_r;         // Borrow-not flag
   reg             nbn_r;        // Nibble borrow-not flag
   reg             nz_r;         // Null result flag
   reg             pdn_r;        // Powerdown flag
   reg             to_r;         // Timeout flag
   reg  [PC_W-1:0] pc_r;         // Program counter
   reg  [6:0]      win_r;        // Register window index
   reg  [7:0]      wdog_r;       // Watchdog counter
   reg  [7:0]      wpre_r;       // Watchdog prescaler
   reg  [7:0]      file_r [0:FILE_DEPTH-1]; // Register file
   reg  [31:0]     rd_nxt;       // Read data mux
   reg             err_nxt;      // Unmapped address
   wire            xfer;         // Access completes this edge
   wire            wr;           // Completing write
   wire            exec;         // Instruction executes this edge
   wire [7:0]      fval;         // Operand register value
   wire [7:0]      alu_res;      // ALU result
   wire            alu_bn;       // ALU borrow-not
   wire            alu_nbn;      // ALU nibble borrow-not
   wire            alu_nz;       // ALU zero
   wire            upd_ar;       // Arithmetic flags update
   wire            upd_nz;       // Zero flag update
   wire [PC_W-1:0] stk_top;      // Top of stack
   wire [STK_LOG2-1:0] stk_ptr;  // Stack pointer
   wire            stk_push;     // Software push
   wire            stk_pop;      // Return pop
   wire            busy;         // Instruction in flight
   wire            file_wr_ex;   // Execution writes the file

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Address match on a word offset
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // Operations whose result may go to a register
   function is_reg_op;
      input [2:0] op;
      begin
         is_reg_op = (op == `OP_SUB_REG) || (op == `OP_XOR_REG) || (op == `OP_SWAP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Instruction clock

   // Divider gives one enable every four pclk periods
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r  <= 3'h0;
         tick_r <= 1'b0;
      end else if (div_r == `INSTR_DIV - 3'h1) begin
         div_r  <= 3'h0;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 3'h1;
         tick_r <= 1'b0;
      end
   end

   // Oscillator stopped model: no instruction executes while in low power
   // halt while sleeping
   assign exec = tick_r && pend_r && !ret2_r && !low_power;
   assign busy = pend_r || ret2_r;

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   assign fval = file_r[faddr_r];

   exec_alu u_alu (
      .op             (op_r),
      .acc            (acc_r),
      .literal        (lit_r),
      .fval           (fval),
      .result         (alu_res),
      .borrow_not     (alu_bn),
      .nib_borrow_not (alu_nbn),
      .null_res       (alu_nz),
      .upd_arith      (upd_ar),
      .upd_null       (upd_nz)
   );

   assign wr       = xfer && pwrite;
   assign stk_push = wr && hit(paddr, `OFS_STACK);
   assign stk_pop  = exec && (op_r == `OP_RETURN);

   return_stack #(
      .DEPTH_LOG2 (STK_LOG2),
      .PC_W       (PC_W)
   ) u_stack (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (stk_push),
      .push_val  (pwdata[PC_W-1:0]),
      .pop       (stk_pop),
      .stack_top (stk_top),
      .ptr       (stk_ptr)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB handshake

   // One wait state: pready rises in the second access cycle
   assign xfer = psel && penable && pready;

   // Read mux and unmapped decode
   always @* begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         `OFS_CTRL: begin
            rd_nxt[`CTRL_OP_MSB:`CTRL_OP_LSB] = op_r;
            rd_nxt[`CTRL_DEST_BIT]             = dest_r;
            rd_nxt[`CTRL_F_MSB:`CTRL_F_LSB]   = faddr_r;
            rd_nxt[`CTRL_K_MSB:`CTRL_K_LSB]   = lit_r;
            rd_nxt[`CTRL_GO_BIT]               = busy;
         end
         `OFS_ACC:       rd_nxt[7:0] = acc_r;
         `OFS_STATUS: begin
            rd_nxt[`ST_BORROW_N]     = bn_r;
            rd_nxt[`ST_NIB_BORROW_N] = nbn_r;
            rd_nxt[`ST_NULL]         = nz_r;
            rd_nxt[`ST_POWERDOWN]    = pdn_r;
            rd_nxt[`ST_TIMEOUT]      = to_r;
            rd_nxt[`ST_SLEEPING]     = low_power;
            rd_nxt[`ST_BUSY]         = busy;
         end
         `OFS_PC:        rd_nxt[PC_W-1:0] = pc_r;
         `OFS_STACK: begin
            rd_nxt[PC_W-1:0] = stk_top;
            rd_nxt[16+STK_LOG2-1:16] = stk_ptr;
         end
         `OFS_FILE_ADDR: rd_nxt[6:0] = win_r;
         `OFS_FILE_DATA: rd_nxt[7:0] = file_r[win_r];
         `OFS_WDOG:      rd_nxt[15:0] = {wpre_r, wdog_r};
         default:        err_nxt = 1'b1;
      endcase
   end

   // Registered answer, every output from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && err_nxt;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction word and sequencing

   // Control register write loads an instruction; go bit queues it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r    <= `OP_NOP;
         dest_r  <= 1'b0;
         faddr_r <= 7'h00;
         lit_r   <= 8'h00;
         pend_r  <= 1'b0;
         ret2_r  <= 1'b0;
      end else begin
         // Writes while busy are ignored so operands stay stable
         if (wr && hit(paddr, `OFS_CTRL) && !busy) begin
            op_r    <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
            dest_r  <= pwdata[`CTRL_DEST_BIT];
            faddr_r <= pwdata[`CTRL_F_MSB:`CTRL_F_LSB];
            lit_r   <= pwdata[`CTRL_K_MSB:`CTRL_K_LSB];
            pend_r  <= pwdata[`CTRL_GO_BIT];
         end else if (exec) begin
            pend_r <= 1'b0;
            ret2_r <= (op_r == `OP_RETURN);
         end else if (tick_r && ret2_r) begin
            ret2_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator and program counter

   // Result to accumulator for literal ops or destination zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= 8'h00;
      end else if (exec && (op_r == `OP_SUB_LIT || op_r == `OP_XOR_LIT)) begin
         acc_r <= alu_res;
      end else if (exec && is_reg_op(op_r) && !dest_r) begin
         acc_r <= alu_res;
      end else if (wr && hit(paddr, `OFS_ACC)) begin
         acc_r <= pwdata[7:0];
      end
   end

   // PC steps by one; return loads the top of stack
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= {PC_W{1'b0}};
      end else if (stk_pop) begin
         pc_r <= stk_top;
      end else if (exec) begin
         pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
      end else if (wr && hit(paddr, `OFS_PC)) begin
         pc_r <= pwdata[PC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags

   // Arithmetic flags change only for the ops that own them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {nz_r, nbn_r, bn_r} <= `RST_STATUS_FLAGS;
      end else if (exec) begin
         // carry out of bit 7 and bit 3 means no borrow
         if (upd_ar) begin
            bn_r  <= alu_bn;
            nbn_r <= alu_nbn;
         end
         // XOR touches only the zero flag
         if (upd_nz) begin
            nz_r <= alu_nz;
         end
      end else if (wr && hit(paddr, `OFS_STATUS)) begin
         bn_r  <= pwdata[`ST_BORROW_N];
         nbn_r <= pwdata[`ST_NIB_BORROW_N];
         nz_r  <= pwdata[`ST_NULL];
      end
   end

   // Powerdown and timeout flags; only sleep changes them after reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdn_r <= `RST_POWERDOWN;
         to_r <= `RST_TIMEOUT;
      end else if (exec && op_r == `OP_SLEEP) begin
         pdn_r <= 1'b0;
         to_r <= 1'b1;
      end
   end

   // Low-power state entry and software wake
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power <= 1'b0;
      end else if (exec && op_r == `OP_SLEEP) begin
         low_power <= 1'b1;
      end else if (wr && hit(paddr, `OFS_STATUS) && pwdata[`ST_WAKE]) begin
         low_power <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog

   // Prescaler counts instruction cycles while awake, counter on wrap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_r <= `RST_WDOG;
         wpre_r <= `RST_WDOG;
      end else if (exec && op_r == `OP_SLEEP) begin
         wdog_r <= 8'h00;
         wpre_r <= 8'h00;
      end else if (tick_r && !low_power) begin
         wpre_r <= wpre_r + 8'h01;
         if (wpre_r == 8'hff) begin
            wdog_r <= wdog_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file

   // destination one writes back the operand register
   assign file_wr_ex = exec && is_reg_op(op_r) && dest_r;

   // Window index for software access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_r <= 7'h00;
      end else if (wr && hit(paddr, `OFS_FILE_ADDR)) begin
         win_r <= pwdata[6:0];
      end
   end

   // Single write port; execution wins over a software write
   always @(posedge pclk) begin
      if (file_wr_ex) begin
         file_r[faddr_r] <= alu_res;
      end else if (wr && hit(paddr, `OFS_FILE_DATA)) begin
         file_r[win_r] <= pwdata[7:0];
      end
   end

endmodule

`default_nettype wire

// >>> logic/exec_defines.vh
// Register offsets, field positions, reset values and timing counts of the execution core
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// Register byte offsets on the APB bus
`define OFS_CTRL        8'h00
`define OFS_ACC         8'h04
`define OFS_STATUS      8'h08
`define OFS_PC          8'h0c
`define OFS_STACK       8'h10
`define OFS_FILE_ADDR   8'h14
`define OFS_FILE_DATA   8'h18
`define OFS_WDOG        8'h1c

// Instruction word fields in the control register
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     2
`define CTRL_DEST_BIT   3
`define CTRL_F_LSB      4
`define CTRL_F_MSB      10
`define CTRL_K_LSB      16
`define CTRL_K_MSB      23
`define CTRL_GO_BIT     31

// Operation codes
`define OP_NOP          3'h0
`define OP_RETURN       3'h1
`define OP_SLEEP        3'h2
`define OP_SUB_LIT      3'h3
`define OP_SUB_REG      3'h4
`define OP_XOR_LIT      3'h5
`define OP_XOR_REG      3'h6
`define OP_SWAP         3'h7

// Status register bit positions
`define ST_BORROW_N     0
`define ST_NIB_BORROW_N 1
`define ST_NULL         2
`define ST_POWERDOWN    3
`define ST_TIMEOUT      4
`define ST_SLEEPING     5
`define ST_BUSY         6
`define ST_WAKE         8

// Reset values
`define RST_STATUS_FLAGS 3'h0
`define RST_POWERDOWN    1'b1
`define RST_TIMEOUT      1'b1
`define RST_WDOG         8'h00

// Instruction cycle is four clock periods of pclk
`define INSTR_DIV        3'h4

`endif

// >>> logic/return_stack.v
// Circular hardware return stack holding program counter values
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
   parameter DEPTH_LOG2 = 3,
   parameter PC_W       = 13
) (
   // Clock and reset
   input  wire            pclk,
   input  wire            presetn,
   // Push and pop strobes
   input  wire            push,
   input  wire [PC_W-1:0] push_val,
   input  wire            pop,
   // Top of stack and pointer
   output wire [PC_W-1:0] stack_top,
   output wire [DEPTH_LOG2-1:0] ptr
);

   reg [PC_W-1:0]       mem_r [0:(1<<DEPTH_LOG2)-1]; // Stack slots
   reg [DEPTH_LOG2-1:0] ptr_r;                       // Next free slot
   wire [DEPTH_LOG2-1:0] top_idx;                    // Last written slot

   // Overflow and underflow simply wrap, no error flag
   assign top_idx   = ptr_r - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
   assign stack_top = mem_r[top_idx];
   assign ptr       = ptr_r;

   // Pointer update, push wins if both come at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= {DEPTH_LOG2{1'b0}};
      end else if (push) begin
         ptr_r <= ptr_r + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
      end else if (pop) begin
         ptr_r <= top_idx;
      end
   end

   // Slot storage, no reset needed for data
   always @(posedge pclk) begin
      if (push) begin
         mem_r[ptr_r] <= push_val;
      end
   end

endmodule

`default_nettype wire

// >>> tb/exec_core_assertions.sv
// Port-level assertions for the execution core
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"
module exec_core_checker (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Core state
   input wire logic        low_power
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // Completed transfers of interest
   wire done    = psel && penable && pready;
   wire rd_done = done && !pwrite;
   wire sleep_w = done && pwrite && paddr == `OFS_CTRL && pwdata[31] && pwdata[2:0] == `OP_SLEEP;
   wire wake_w  = done && pwrite && paddr == `OFS_STATUS && pwdata[`ST_WAKE];
   // Setup cycle followed by first access cycle
   sequence setup_access;
      psel && !penable ##1 psel && penable;
   endsequence
   // Sleep request accepted on the bus
   sequence sleep_req;
      sleep_w;
   endsequence
   ////////////////////////////////////////
   // One wait state, always
   pready_wait_a: assert property (setup_access |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_pairs_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // Unmapped read gives error and zero
   err_unmapped_a: assert property (rd_done && paddr == 8'h20 |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   sleep_enter_a: assert property (sleep_req |-> ##[1:8] low_power)
      else $error("sleep did not enter low power");
   low_hold_a: assert property ($fell(low_power) |-> $past(wake_w) || $past(wake_w, 2))
      else $error("low power left without wake");
   wake_exit_a: assert property (wake_w |-> ##[1:4] !low_power)
      else $error("wake did not leave low power");
   // Read data is captured one edge before completion, so look at the state it saw
   sleep_flags_a: assert property (rd_done && paddr == `OFS_STATUS && $past(low_power) |->
      prdata[5:3] == 3'b110) else $error("status flags wrong while asleep");
   wdog_zero_a: assert property (rd_done && paddr == `OFS_WDOG && $past(low_power) |->
      prdata[15:0] == 16'h0000) else $error("watchdog not cleared while asleep");
endmodule
bind exec_core exec_core_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .low_power(low_power));
`default_nettype wire

// >>> tb/test_cpu_instruction_subset_exec.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"
module test_cpu_instruction_subset_exec;
   // Stimulus
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   // Design outputs
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         low_power;
   // Bench state
   integer      seed      = 32'h35e8;
   integer      error_cnt = 0;
   integer      checks    = 0;
   integer      cyc       = 0;
   integer      i;
   logic [31:0] rd;
   logic        er;
   logic [2:0]  op;
   logic [2:0]  fl;
   logic [7:0]  w;
   logic [7:0]  fv;
   logic [7:0]  k;
   logic [6:0]  f;
   logic        dst;
   logic        to_acc;
   logic [10:0] e;
   logic [12:0] s1;
   logic [12:0] s2;
   logic [5:0]  pad;
   exec_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_power(low_power));
   always #12.5 pclk = ~pclk;
   ////////////////////////////////////////
   // Verdict, reached once from either path
   task print_verdict;
      begin
         if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         print_verdict;
      end
   end
   // Word compare
   task cmp_val(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Single flag compare
   task cmp_bit(input logic got, input logic exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // One APB transfer; held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Poll busy; bounded so a stuck core cannot hide
   task busy_wait;
      integer n;
      begin
         n = 0;
         do begin
            apb(1'b0, `OFS_CTRL, 32'h0);
            n = n + 1;
         end while (rd[31] !== 1'b0 && n < 10);
         cmp_bit(rd[31], 1'b0);
      end
   endtask
   // Queue one instruction and wait for it
   task run_op(input logic [2:0] o, input logic d, input logic [6:0] a, input logic [7:0] l);
      begin
         apb(1'b1, `OFS_CTRL, {1'b1, 7'h00, l, 5'h00, a, d, o});
         busy_wait;
      end
   endtask
   // Expected result and flags {result, null, nibble, borrow}
   function automatic logic [10:0] calc(input logic [2:0] o, input logic [7:0] wv,
      input logic [7:0] fd, input logic [7:0] lit, input logic [2:0] fi);
      logic [7:0] a;
      logic [8:0] s;
      logic [4:0] h;
      begin
         a = (o == `OP_SUB_LIT || o == `OP_XOR_LIT) ? lit : fd;
         // Plain subtraction; a borrow out sets the top bit, flags keep its inverse
         s = {1'b0, a} - {1'b0, wv};
         h = {1'b0, a[3:0]} - {1'b0, wv[3:0]};
         if (o == `OP_SWAP)
            calc = {a[3:0], a[7:4], fi};
         else if (o == `OP_XOR_LIT || o == `OP_XOR_REG)
            calc = {a ^ wv, (a ^ wv) == 8'h00, fi[1:0]};
         else
            calc = {s[7:0], s[7:0] == 8'h00, ~h[4], ~s[8]};
      end
   endfunction
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state: powerdown and timeout set, flags clear
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp_val(rd & 32'h7f, 32'h18);
      // arithmetic, flags and destination, corners first
      for (i = 0; i < 30; i = i + 1) begin
         op = `OP_SUB_LIT + 3'(i % 5);
         {w, fv, k, f, dst} = $random(seed);
         rd = $random(seed);
         fl = rd[2:0];
         if (i < 5) begin
            fv = w;
            k  = w;
         end else if (i < 10) begin
            {w, fv, k, f} = {8'h01, 8'h00, 8'h00, 7'h7f};
         end
         apb(1'b1, `OFS_ACC, {24'h0, w});
         apb(1'b1, `OFS_FILE_ADDR, {25'h0, f});
         apb(1'b1, `OFS_FILE_DATA, {24'h0, fv});
         apb(1'b1, `OFS_STATUS, {29'h0, fl});
         run_op(op, dst, f, k);
         e = calc(op, w, fv, k, fl);
         to_acc = op == `OP_SUB_LIT || op == `OP_XOR_LIT || !dst;
         apb(1'b0, `OFS_ACC, 32'h0);
         cmp_val(rd, {24'h0, to_acc ? e[10:3] : w});
         apb(1'b0, `OFS_FILE_DATA, 32'h0);
         cmp_val(rd, {24'h0, to_acc ? fv : e[10:3]});
         apb(1'b0, `OFS_STATUS, 32'h0);
         cmp_val({29'h0, rd[2:0]}, {29'h0, e[2:0]});
      end
      // return pops the stack, flags kept
      {s1, s2, pad} = $random(seed);
      apb(1'b1, `OFS_STACK, {19'h0, s1});
      apb(1'b1, `OFS_STACK, {19'h0, s2});
      apb(1'b1, `OFS_CTRL, {29'h10000000, `OP_RETURN});
      apb(1'b0, `OFS_CTRL, 32'h0);
      cmp_bit(rd[31], 1'b1);
      busy_wait;
      apb(1'b0, `OFS_PC, 32'h0);
      cmp_val(rd, {19'h0, s2});
      apb(1'b0, `OFS_STACK, 32'h0);
      cmp_val({19'h0, rd[12:0]}, {19'h0, s1});
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp_val({29'h0, rd[2:0]}, {29'h0, fl});
      // Idle operation steps on from the popped address
      run_op(`OP_NOP, 1'b0, 7'h00, 8'h00);
      apb(1'b0, `OFS_PC, 32'h0);
      cmp_val(rd, {19'h0, s2 + 13'h1});
      // sleep, queued op held until wake
      apb(1'b1, `OFS_ACC, 32'ha5);
      run_op(`OP_SLEEP, 1'b0, 7'h00, 8'h00);
      cmp_bit(low_power, 1'b1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp_val({26'h0, rd[5:0]}, {26'h0, 3'b110, fl});
      apb(1'b0, `OFS_WDOG, 32'h0);
      cmp_val({16'h0, rd[15:0]}, 32'h0);
      apb(1'b1, `OFS_CTRL, {1'b1, 7'h00, 8'h5a, 13'h0, `OP_XOR_LIT});
      repeat (20) @(posedge pclk);
      apb(1'b0, `OFS_ACC, 32'h0);
      cmp_val(rd, 32'ha5);
      apb(1'b1, `OFS_STATUS, {23'h0, 1'b1, 5'h00, fl});
      busy_wait;
      cmp_bit(low_power, 1'b0);
      apb(1'b0, `OFS_ACC, 32'h0);
      cmp_val(rd, 32'hff);
      // Unmapped read and write are refused
      apb(1'b0, 8'h20, 32'h0);
      cmp_bit(er, 1'b1);
      cmp_val(rd, 32'h0);
      apb(1'b1, 8'h24, 32'h1);
      cmp_bit(er, 1'b1);
      print_verdict;
   end
endmodule
`default_nettype wire
